// File: common/csa_params.svh
`ifndef CSA_PARAMS_SVH
`define CSA_PARAMS_SVH

// instruction word layout
`define CSA_F_OPC_HI     31
`define CSA_F_OPC_LO     26
`define CSA_F_UPD_EQ     25
`define CSA_F_UPD_BRW    24
`define CSA_F_WR         23
`define CSA_F_IMM        22
`define CSA_F_PRED_HI    21
`define CSA_F_PRED_LO    18
`define CSA_F_DST_HI     17
`define CSA_F_DST_LO     9
`define CSA_F_SRC_HI     8
`define CSA_F_SRC_LO     0

// opcodes
`define CSA_OPC_CSUB     6'h38
`define CSA_OPC_SXCMP    6'h31

// predicate value meaning always
`define CSA_PRED_ALWAYS  4'hf

// reset values
`define CSA_ZFLAG_RST    1'h0
`define CSA_CFLAG_RST    1'h0

// clocks from accepted start to commit
`define CSA_EXEC_CLOCKS  4

`endif

// File: common/csa_pkg.sv
package csa_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RD,
        ST_EX,
        ST_WB
    } csa_state_t;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_CSUB,
        OP_SXCMP
    } csa_op_t;

endpackage : csa_pkg

// File: rtl/csa_regfile.sv
`timescale 1ns/100ps

// two registered read ports, one write port
module csa_regfile #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 512,
    localparam int AW   = $clog2(DEPTH)
) (
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    input  wire logic             i_we,
    input  wire logic [AW-1:0]    i_waddr,
    input  wire logic [WIDTH-1:0] i_wdata,
    input  wire logic [AW-1:0]    i_raddr_a,
    input  wire logic [AW-1:0]    i_raddr_b,
    output logic      [WIDTH-1:0] o_rdata_a,
    output logic      [WIDTH-1:0] o_rdata_b
);

    logic [WIDTH-1:0] mem_reg [DEPTH];

    generate
        if (DEPTH < 2) begin : g_bad_depth
            $error("csa_regfile: depth too small");
        end
    endgenerate

    // array has no reset so it maps onto block memory
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem_reg[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_rdata_a <= '0;
            o_rdata_b <= '0;
        end else begin
            o_rdata_a <= mem_reg[i_raddr_a];
            o_rdata_b <= mem_reg[i_raddr_b];
        end
    end

endmodule : csa_regfile

// File: rtl/csa_alu.sv
`timescale 1ns/100ps
`include "csa_params.svh"

module csa_alu #(
    parameter int REG_DEPTH = 512,
    parameter int WIDTH     = 32
) (
    input  wire logic        I_MCLK,
    input  wire logic        I_NRST,
    input  wire logic        I_START,
    input  wire logic [31:0] I_INSTR,
    input  wire logic        I_LD_WE,
    input  wire logic [8:0]  I_LD_ADDR,
    input  wire logic [31:0] I_LD_DATA,
    input  wire logic [8:0]  I_PEEK_ADDR,
    output logic             O_BUSY,
    output logic             O_DONE,
    output logic             O_BAD_OP,
    output logic             O_ZFLAG,
    output logic             O_CFLAG,
    output logic [31:0]      O_PEEK_DATA
);

    generate
        if (REG_DEPTH != 512 || WIDTH != 32) begin : g_bad_cfg
            $error("csa_alu: 9-bit fields need 512 longs of 32 bits");
        end
    endgenerate

    csa_pkg::csa_state_t state_reg;
    csa_pkg::csa_state_t state_next;
    csa_pkg::csa_op_t    op;
    logic [31:0]         instr_reg;
    logic [31:0]         d_reg;
    logic [31:0]         s_reg;
    logic [31:0]         rdata_d;
    logic [31:0]         rdata_s;
    logic [31:0]         s_val;
    logic [8:0]          raddr_a;
    logic                mem_we;
    logic [8:0]          mem_waddr;
    logic [31:0]         mem_wdata;
    logic                exec_ok;
    logic                upd_eq;
    logic                upd_borrow;
    logic                do_wr;
    logic [3:0]          pred;
    logic                su_geq;
    logic [31:0]         su_diff;
    logic [32:0]         sx_diff;
    logic                z_new;
    logic                c_new;
    logic                res_we;
    logic [31:0]         res_val;
    logic                zflag_reg;
    logic                cflag_reg;

    assign upd_eq     = instr_reg[`CSA_F_UPD_EQ];
    assign upd_borrow = instr_reg[`CSA_F_UPD_BRW];
    assign do_wr      = instr_reg[`CSA_F_WR];
    assign pred       = instr_reg[`CSA_F_PRED_HI:`CSA_F_PRED_LO];

    // decode
    always_comb begin
        unique case (instr_reg[`CSA_F_OPC_HI:`CSA_F_OPC_LO])
            `CSA_OPC_CSUB:   op = csa_pkg::OP_CSUB;
            `CSA_OPC_SXCMP:  op = csa_pkg::OP_SXCMP;
            default:         op = csa_pkg::OP_NONE;
        endcase
    end

    // predicate indexed by {borrow, equality}; all ones always runs
    assign exec_ok = (pred == `CSA_PRED_ALWAYS) || pred[{cflag_reg, zflag_reg}];

    // sequencer: accept, read, latch operands, commit
    always_comb begin
        unique case (state_reg)
            csa_pkg::ST_IDLE: state_next = I_START ? csa_pkg::ST_RD : csa_pkg::ST_IDLE;
            csa_pkg::ST_RD:   state_next = csa_pkg::ST_EX;
            csa_pkg::ST_EX:   state_next = csa_pkg::ST_WB;
            csa_pkg::ST_WB:   state_next = csa_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_NRST) begin
            state_reg <= csa_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_NRST) begin
            instr_reg <= 32'h0;
        end else if (state_reg == csa_pkg::ST_IDLE && I_START) begin
            instr_reg <= I_INSTR;
        end
    end

    // literal sources are zero-extended
    assign s_val = instr_reg[`CSA_F_IMM] ?
                   {23'h0, instr_reg[`CSA_F_SRC_HI:`CSA_F_SRC_LO]} : rdata_s;

    always_ff @(posedge I_MCLK) begin
        if (!I_NRST) begin
            d_reg <= 32'h0;
            s_reg <= 32'h0;
        end else if (state_reg == csa_pkg::ST_EX) begin
            d_reg <= rdata_d;
            s_reg <= s_val;
        end
    end

    // unsigned conditional subtract
    assign su_geq  = d_reg >= s_reg;
    assign su_diff = d_reg - s_reg;

    // signed extended: 33 bits hold d-s-c exactly, so sign never wraps
    assign sx_diff = {d_reg[31], d_reg} - {s_reg[31], s_reg} - {32'h0, cflag_reg};

    always_comb begin
        z_new   = zflag_reg;
        c_new   = cflag_reg;
        res_we  = 1'b0;
        res_val = d_reg;
        unique case (op)
            csa_pkg::OP_CSUB: begin
                z_new   = d_reg == s_reg;
                c_new   = su_geq;
                res_we  = do_wr && su_geq;
                res_val = su_diff;
            end
            csa_pkg::OP_SXCMP: begin
                z_new   = zflag_reg && (sx_diff[31:0] == 32'h0);
                c_new   = sx_diff[32];
                res_we  = do_wr;
                res_val = sx_diff[31:0];
            end
            csa_pkg::OP_NONE: begin
                res_we  = 1'b0;
            end
        endcase
    end

    // flags move only on commit, only with their option
    always_ff @(posedge I_MCLK) begin
        if (!I_NRST) begin
            zflag_reg <= `CSA_ZFLAG_RST;
            cflag_reg <= `CSA_CFLAG_RST;
        end else if (state_reg == csa_pkg::ST_WB && exec_ok) begin
            if (upd_eq) begin
                zflag_reg <= z_new;
            end
            if (upd_borrow) begin
                cflag_reg <= c_new;
            end
        end
    end

    // loads accepted only while idle so they never race a commit
    always_comb begin
        mem_we    = 1'b0;
        mem_waddr = I_LD_ADDR;
        mem_wdata = I_LD_DATA;
        if (state_reg == csa_pkg::ST_WB) begin
            mem_we    = res_we && exec_ok;
            mem_waddr = instr_reg[`CSA_F_DST_HI:`CSA_F_DST_LO];
            mem_wdata = res_val;
        end else if (state_reg == csa_pkg::ST_IDLE) begin
            mem_we    = I_LD_WE;
        end
    end

    assign raddr_a = (state_reg == csa_pkg::ST_RD) ?
                     instr_reg[`CSA_F_DST_HI:`CSA_F_DST_LO] : I_PEEK_ADDR;

    csa_regfile #(
        .WIDTH (WIDTH),
        .DEPTH (REG_DEPTH)
    ) u_regfile (
        .i_clk     (I_MCLK),
        .i_nrst    (I_NRST),
        .i_we      (mem_we),
        .i_waddr   (mem_waddr),
        .i_wdata   (mem_wdata),
        .i_raddr_a (raddr_a),
        .i_raddr_b (instr_reg[`CSA_F_SRC_HI:`CSA_F_SRC_LO]),
        .o_rdata_a (rdata_d),
        .o_rdata_b (rdata_s)
    );

    assign O_BUSY      = state_reg != csa_pkg::ST_IDLE;
    assign O_DONE      = state_reg == csa_pkg::ST_WB;
    assign O_BAD_OP    = O_DONE && (op == csa_pkg::OP_NONE);
    assign O_ZFLAG     = zflag_reg;
    assign O_CFLAG     = cflag_reg;
    assign O_PEEK_DATA = rdata_d;

    logic wb_sub;
    logic wb_sx;
    assign wb_sub = O_DONE && exec_ok && op == csa_pkg::OP_CSUB;
    assign wb_sx  = O_DONE && exec_ok && op == csa_pkg::OP_SXCMP;

    chk_exec_latency: assert property (
        @(posedge I_MCLK) disable iff (!I_NRST)
        (state_reg == csa_pkg::ST_IDLE && I_START) |-> !O_DONE ##1 !O_DONE ##1 !O_DONE ##1 O_DONE)
        else $error("commit not on fourth clock");

    chk_sub_borrow: assert property (
        @(posedge I_MCLK) disable iff (!I_NRST)
        (wb_sub && upd_borrow) |=> O_CFLAG == ($past(d_reg) >= $past(s_reg)))
        else $error("unsigned borrow flag wrong");

    chk_sub_equal: assert property (
        @(posedge I_MCLK) disable iff (!I_NRST)
        (wb_sub && upd_eq) |=> O_ZFLAG == ($past(d_reg) == $past(s_reg)))
        else $error("unsigned equality flag wrong");

    chk_sub_write: assert property (
        @(posedge I_MCLK) disable iff (!I_NRST)
        wb_sub |-> mem_we == (do_wr && d_reg >= s_reg) && mem_wdata == d_reg - s_reg)
        else $error("conditional subtract write wrong");

    chk_sx_borrow: assert property (
        @(posedge I_MCLK) disable iff (!I_NRST)
        (wb_sx && upd_borrow) |=> O_CFLAG == ($signed({{2{$past(d_reg[31])}}, $past(d_reg)})
            < $signed({{2{$past(s_reg[31])}}, $past(s_reg)}) + $signed({33'h0, $past(cflag_reg)})))
        else $error("signed borrow flag wrong");

    chk_sx_equal: assert property (
        @(posedge I_MCLK) disable iff (!I_NRST)
        (wb_sx && upd_eq) |=> O_ZFLAG == ($past(zflag_reg)
            && $past(d_reg) == $past(s_reg) + {31'h0, $past(cflag_reg)}))
        else $error("signed equality flag wrong");

    chk_sx_write: assert property (
        @(posedge I_MCLK) disable iff (!I_NRST)
        wb_sx |-> mem_we == do_wr && mem_wdata == d_reg - s_reg - {31'h0, cflag_reg})
        else $error("signed compare write wrong");

    chk_pred_hold: assert property (
        @(posedge I_MCLK) disable iff (!I_NRST)
        (O_DONE && !exec_ok) |-> !mem_we ##1 ($stable(O_ZFLAG) && $stable(O_CFLAG)))
        else $error("failed predicate changed state");

    chk_flag_keep: assert property (
        @(posedge I_MCLK) disable iff (!I_NRST)
        (O_DONE && !upd_eq) |=> $stable(O_ZFLAG))
        else $error("equality flag moved without option");

endmodule : csa_alu

// File: testbench/csa_seq.sv
`timescale 1ns/100ps

// sequencer side: loads operands, issues one instruction at a time
module csa_seq (
    input  wire logic        i_clk,
    input  wire logic        i_done,
    output logic             o_start,
    output logic [31:0]      o_instr,
    output logic             o_ld_we,
    output logic [8:0]       o_ld_addr,
    output logic [31:0]      o_ld_data
);
    initial begin
        o_start   = 1'h0;
        o_instr   = 32'h0;
        o_ld_we   = 1'h0;
        o_ld_addr = 9'h0;
        o_ld_data = 32'h0;
    end

    task load(input logic [8:0] a, input logic [31:0] v);
        @(posedge i_clk);
        o_ld_we   <= 1'h1;
        o_ld_addr <= a;
        o_ld_data <= v;
        @(posedge i_clk);
        o_ld_we   <= 1'h0;
        o_ld_data <= ~v;
    endtask : load

    // chains rely on the program keeping borrow updates on every step
    task issue(input logic [31:0] ins, output int n);
        @(posedge i_clk);
        o_start <= 1'h1;
        o_instr <= ins;
        n = 0;
        do begin
            @(posedge i_clk);
            o_start <= 1'h0;
            o_instr <= ~ins;
            #1;
            n++;
        end while (i_done !== 1'h1 && n < 16);
    endtask : issue
endmodule : csa_seq

// File: testbench/tb.sv
`timescale 1ns/100ps

module tb;
    logic        mclk = 1'h0;
    logic        nrst = 1'h0;
    logic        start;
    logic [31:0] instr;
    logic        ld_we;
    logic [8:0]  ld_addr;
    logic [31:0] ld_data;
    logic [8:0]  peek_addr = 9'h0;
    logic        busy;
    logic        done;
    logic        bad_op;
    logic        zflag;
    logic        cflag;
    logic [31:0] peek_data;
    logic [31:0] mdl [0:511];
    logic        zf = 1'h0;
    logic        cf = 1'h0;
    int          miscompares = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    logic [8:0]  pd [9] = '{9'h5, 9'h6, 9'h5, 9'h6, 9'h7, 9'h7, 9'h7, 9'h1, 9'h1};
    logic [8:0]  ps [9] = '{9'h6, 9'h5, 9'h9, 9'h8, 9'h8, 9'h7, 9'hb, 9'h2, 9'h3};

    always #2.5 mclk = ~mclk;

    csa_alu #(.REG_DEPTH(512), .WIDTH(32)) u_csa_alu (
        .I_MCLK(mclk), .I_NRST(nrst), .I_START(start), .I_INSTR(instr),
        .I_LD_WE(ld_we), .I_LD_ADDR(ld_addr), .I_LD_DATA(ld_data),
        .I_PEEK_ADDR(peek_addr), .O_BUSY(busy), .O_DONE(done), .O_BAD_OP(bad_op),
        .O_ZFLAG(zflag), .O_CFLAG(cflag), .O_PEEK_DATA(peek_data));

    csa_seq u_csa_seq (
        .i_clk(mclk), .i_done(done), .o_start(start), .o_instr(instr),
        .o_ld_we(ld_we), .o_ld_addr(ld_addr), .o_ld_data(ld_data));

    task finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    // a hang counts as a mismatch
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task ld(input logic [8:0] a, input logic [31:0] v);
        mdl[a] = v;
        u_csa_seq.load(a, v);
    endtask : ld

    // fx = {upd_eq, upd_borrow, wr, imm}
    task run(input logic [5:0] opc, input logic [3:0] fx, input logic [3:0] pred,
             input logic [8:0] d, input logic [8:0] s);
        logic [31:0] dv;
        logic [31:0] sv;
        logic        ex;
        logic        nz;
        logic        nc;
        logic        wr;
        int          n;
        dv = mdl[d];
        sv = fx[0] ? {23'h0, s} : mdl[s];
        ex = (pred == 4'hf) || pred[{cf, zf}];
        nz = zf;
        nc = cf;
        wr = 1'h0;
        if (ex && opc == 6'h38) begin
            nz = (dv == sv);
            nc = (dv >= sv);
            wr = fx[1] && nc;
            sv = dv - sv;
        end else if (ex && opc == 6'h31) begin
            nz = zf && (dv == sv + {31'h0, cf});
            nc = $signed({dv[31], dv}) < $signed({sv[31], sv}) + $signed({32'h0, cf});
            wr = fx[1];
            sv = dv - sv - {31'h0, cf};
        end
        if (ex && fx[3]) zf = nz;
        if (ex && fx[2]) cf = nc;
        if (wr) mdl[d] = sv;
        u_csa_seq.issue({opc, fx, pred, d, s}, n);
        check("done latency", n, 3);
        check("bad op", bad_op, {31'h0, opc != 6'h38 && opc != 6'h31});
        check("busy", busy, 32'h1);
        @(posedge mclk);
        #1;
        check("zflag", zflag, zf);
        check("cflag", cflag, cf);
        check("idle", busy, 32'h0);
        @(posedge mclk);
        peek_addr <= d;
        @(posedge mclk);
        #1;
        check("dest", peek_data, mdl[d]);
    endtask : run

    // {z, c}: 0 = 00, 1 = 01, 2 = 10, 3 = 11; z alone needs a signed step
    task preset(input int k);
        case (k)
            0: run(6'h38, 4'hc, 4'hf, 9'h3, 9'h4);
            1: run(6'h38, 4'hc, 4'hf, 9'h3, 9'h2);
            default: run(6'h38, 4'hc, 4'hf, 9'h3, 9'h3);
        endcase
        if (k == 2) run(6'h31, 4'hc, 4'hf, 9'h1, 9'h2);
    endtask : preset

    initial begin
        repeat (16) @(posedge mclk);
        nrst <= 1'h1;
        @(posedge mclk);
        #1;
        check("reset flags", {busy, done, zflag, cflag}, 32'h0);
        ld(9'h1, 32'h3); ld(9'h2, 32'h2); ld(9'h3, 32'h3); ld(9'h4, 32'h4);
        ld(9'h5, 32'h80000000); ld(9'h6, 32'h7fffffff); ld(9'h7, 32'hfffffffe);
        ld(9'h8, 32'hffffffff); ld(9'h9, 32'h1); ld(9'ha, 32'h200);
        ld(9'hb, 32'hfffffffd); ld(9'hc, 32'h0);
        run(6'h38, 4'he, 4'hf, 9'h1, 9'h2);
        ld(9'h1, 32'h3);
        run(6'h38, 4'he, 4'hf, 9'h1, 9'h3);
        run(6'h38, 4'he, 4'hf, 9'h3, 9'h4);
        run(6'h38, 4'he, 4'hf, 9'h5, 9'h6);
        run(6'h38, 4'hc, 4'hf, 9'h1, 9'h2);
        run(6'h38, 4'hf, 4'hf, 9'ha, 9'h1ff);
        run(6'h38, 4'h2, 4'hf, 9'h4, 9'h2);
        $display("test compare-subtract done");
        ld(9'h1, 32'h3);
        ld(9'h4, 32'h4);
        ld(9'h5, 32'h80000000);
        for (int k = 0; k < 4; k++) begin
            for (int j = 0; j < 9; j++) begin
                preset(k);
                run(6'h31, 4'hc, 4'hf, pd[j], ps[j]);
            end
        end
        ld(9'h5, 32'h80000000);
        preset(0);
        run(6'h31, 4'he, 4'hf, 9'h5, 9'h9);
        run(6'h31, 4'h0, 4'hf, 9'h6, 9'h8);
        preset(0);
        run(6'h31, 4'hc, 4'hf, 9'h8, 9'hc);
        $display("test signed extended done");
        for (int k = 0; k < 4; k++) begin
            ld(9'h1, 32'h3);
            preset(k);
            run(6'h38, 4'he, 4'h5, 9'h1, 9'h2);
        end
        run(6'h38, 4'he, 4'h0, 9'h1, 9'h2);
        run(6'h00, 4'he, 4'hf, 9'h1, 9'h2);
        $display("test predicate done");
        finish_test();
    end
endmodule : tb
